// *** rtl/cfd_map.svh ***
`ifndef CFD_MAP_SVH
`define CFD_MAP_SVH
`define CFD_MODE_OFF   4'h0
`define CFD_CHAN_OFF   4'h4
`define CFD_STAT_OFF   4'h8
`define CFD_FW_MSB     9
`define CFD_FW_LSB     0
`define CFD_SINC4_BIT  15
`define CFD_AVGLO_BIT  16
`define CFD_AVGHI_BIT  17
`define CFD_NOTCH_BIT  20
`define CFD_CHOP_BIT   23
`define CFD_FW_RST     10'h060
`define CFD_NOTCH_FW   10'h060
`define CFD_MULT_SINC3 5'h03
`define CFD_MULT_SINC4 5'h04
`define CFD_FS_WARM    5'h03
`define CFD_RESP_OKAY  2'h0
`define CFD_RESP_SLV   2'h2
`endif

// *** rtl/cfd_pkg.sv ***
`default_nettype none
package cfd_pkg;
   typedef enum logic {
      CFD_CONV = 1'b0,
      CFD_HOLD = 1'b1
   } cfd_state_e;

   typedef struct packed {
      logic [9:0] filter_word;
      logic       sinc4_sel;
      logic       avg_select_hi;
      logic       avg_select_lo;
      logic       sixty_hz_notch_en;
      logic       chop_en;
   } cfd_cfg_s;

   typedef struct packed {
      cfd_state_e  st;
      cfd_cfg_s    cfg;
      logic [1:0]  chan;
      logic [19:0] samp;
      logic [4:0]  blk;
      logic [31:0] acc;
      logic [31:0] prev;
      logic        have_prev;
      logic        discard;
      logic        pol;
      logic        mod_rst;
      logic [31:0] fifo0;
      logic [31:0] fifo1;
      logic [1:0]  fcnt;
      logic        res_valid;
      logic        aw_rdy;
      logic        w_rdy;
      logic        aw_got;
      logic        w_got;
      logic [3:0]  aw_addr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cfd_state_s;
endpackage
`default_nettype wire

// *** rtl/cfd_decimator.sv ***
`include "cfd_map.svh"
`default_nettype none
// Functional notes
// [RULE1] chop: swap input polarity each conversion, average pairs to cancel offset
// [RULE2] chopped sinc3 rate is master clock over 3*1024*filter word
// [RULE3] filter word is 1..1023; rate falls as the word grows
// [RULE4] chopped sinc3 needs two output periods to settle fully
// [RULE5] channel change resets modulator and filter; first result after full settling
// [RULE6] steps are not detected; accurate data two or three conversions later
// [RULE7] sixty hertz notch at word 96 leaves output rate unchanged
// [RULE8] fast settling postfilter averages 2, 8 or 16 sinc4 results
// [RULE9] both averaging bits zero: fast settling off, no postfilter
// [RULE10] fast settling rate is master clock over (3+avg)*1024*filter word
// [RULE11] fast settling without chop settles in one period, no switch latency
// [RULE12] fast settling: synchronous step all settled, asynchronous step one unsettled
// [RULE13] fast settling with chop keeps rate, settles in two periods
// [RULE14] filter word is mode register bits nine to zero, unsigned
// [RULE15] controller should keep chopped sinc3 at or below 320 Hz
// [RULE16] each settled result is flagged available at end of its period
module cfd_decimator (
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        CE,
   input  wire logic        MOD_BIT,
   input  wire logic        RES_READY,
   output logic             MOD_RESET,
   output logic             CHOP_POL,
   output logic             RES_VALID,
   output logic [31:0]      RES_DATA,
   input  wire logic [3:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [3:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);
   localparam cfd_pkg::cfd_state_s RST_S = '{
      st: cfd_pkg::CFD_CONV,
      cfg: '{filter_word: `CFD_FW_RST, default: 1'b0},
      aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1,
      default: '0};

   cfd_pkg::cfd_state_s s;
   cfd_pkg::cfd_state_s n;
   logic        fast;
   logic [4:0]  navg;
   logic [2:0]  shift;
   logic [4:0]  mult;
   logic [4:0]  warm;
   logic        last_samp;
   logic        last_blk;
   logic        pop;
   logic        room;
   logic        conv_last;
   logic        conv_end;
   logic        stall;
   logic        push;
   logic [31:0] acc_nxt;
   logic [31:0] sub;
   logic [31:0] raw;
   logic        wr_go;
   logic        restart;
   logic        notch_act;
   logic [31:0] mode_rd;
   logic [31:0] stat_rd;
   logic [31:0] wr_val;
   logic [1:0]  cnt;

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign fast = s.cfg.avg_select_hi | s.cfg.avg_select_lo; // [RULE9]
   always_comb begin
      case ({s.cfg.avg_select_hi, s.cfg.avg_select_lo}) // [RULE8]
         2'b01: begin navg = 5'h02; shift = 3'h1; end
         2'b10: begin navg = 5'h08; shift = 3'h3; end
         2'b11: begin navg = 5'h10; shift = 3'h4; end
         default: begin navg = 5'h01; shift = 3'h0; end // [RULE9]
      endcase
   end
   // chop does not alter the multiplier, so fast mode rate is chop-independent
   assign mult = fast ? 5'(`CFD_FS_WARM + navg) // [RULE10] [RULE13]
               : (s.cfg.sinc4_sel ? `CFD_MULT_SINC4 : `CFD_MULT_SINC3); // [RULE2]
   // only the final navg blocks feed the result; earlier blocks fill the sinc
   assign warm = 5'(mult - navg);
   assign last_samp = s.samp == {s.cfg.filter_word - 10'h001, 10'h3ff}; // [RULE2]
   assign last_blk = s.blk == 5'(mult - 5'h01);
   assign pop = s.res_valid && RES_READY;
   assign room = (s.fcnt != 2'h2) || pop;
   assign conv_last = last_samp && last_blk;
   assign conv_end = conv_last && room;
   // a full buffer holds the last sample instead of dropping a result
   assign stall = conv_last && !room;
   assign push = conv_end && !s.discard; // [RULE4] [RULE16]
   assign acc_nxt = s.acc + {31'h0, (s.blk >= warm) && (MOD_BIT ^ s.pol)};
   assign sub = acc_nxt >> shift; // [RULE8]
   // inverted phase counts zeros, so the pair mean removes input offset
   assign raw = (s.cfg.chop_en && s.have_prev) // [RULE1] [RULE6] [RULE12]
              ? 32'((33'(sub) + 33'(s.prev)) >> 1) : sub;
   assign wr_go = s.aw_got && s.w_got && !s.bvalid;
   assign restart = wr_go && (s.aw_addr == `CFD_MODE_OFF || s.aw_addr == `CFD_CHAN_OFF);
   // notch only shows as a status bit; decimation timing stays put
   assign notch_act = s.cfg.sixty_hz_notch_en && s.cfg.chop_en && !s.cfg.sinc4_sel
                    && !fast && s.cfg.filter_word == `CFD_NOTCH_FW; // [RULE7]

   always_comb begin
      mode_rd = '0;
      mode_rd[`CFD_FW_MSB:`CFD_FW_LSB] = s.cfg.filter_word; // [RULE14]
      mode_rd[`CFD_SINC4_BIT] = s.cfg.sinc4_sel;
      mode_rd[`CFD_AVGLO_BIT] = s.cfg.avg_select_lo;
      mode_rd[`CFD_AVGHI_BIT] = s.cfg.avg_select_hi;
      mode_rd[`CFD_NOTCH_BIT] = s.cfg.sixty_hz_notch_en;
      mode_rd[`CFD_CHOP_BIT] = s.cfg.chop_en;
      stat_rd = {24'h0, s.res_valid, notch_act, s.discard, s.fcnt, s.pol, 1'b0, s.st};
   end

   always_comb begin
      n = s;
      n.mod_rst = 1'b0;
      wr_val = '0;
      // conversions run on regardless of input steps
      if (!stall) begin // [RULE6] [RULE12]
         n.st = cfd_pkg::CFD_CONV;
         n.acc = acc_nxt;
         n.samp = last_samp ? 20'h0 : s.samp + 20'h1;
         if (last_samp) begin
            n.blk = s.blk + 5'h01;
         end
      end else begin
         n.st = cfd_pkg::CFD_HOLD;
      end
      if (conv_end) begin
         n.acc = '0;
         n.blk = '0;
         n.prev = sub;
         n.have_prev = 1'b1;
         n.pol = s.pol ^ s.cfg.chop_en; // [RULE1]
         n.discard = 1'b0;
      end
      cnt = s.fcnt - {1'b0, pop};
      if (pop) begin
         n.fifo0 = s.fifo1;
      end
      if (push) begin // [RULE16]
         if (cnt == 2'h0) begin
            n.fifo0 = raw;
         end else begin
            n.fifo1 = raw;
         end
      end
      n.fcnt = cnt + {1'b0, push};
      n.res_valid = n.fcnt != 2'h0;

      if (S_AXI_AWVALID && s.aw_rdy) begin
         n.aw_got = 1'b1;
         n.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s.w_rdy) begin
         n.w_got = 1'b1;
         n.wdata = S_AXI_WDATA;
         n.wstrb = S_AXI_WSTRB;
      end
      if (s.bvalid && S_AXI_BREADY) begin
         n.bvalid = 1'b0;
      end
      if (wr_go) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = restart ? `CFD_RESP_OKAY : `CFD_RESP_SLV;
         if (s.aw_addr == `CFD_MODE_OFF) begin
            wr_val = merge(mode_rd, s.wdata, s.wstrb);
            // a zero word is ignored, keeping the old rate
            if (wr_val[`CFD_FW_MSB:`CFD_FW_LSB] != 10'h0) begin // [RULE3]
               n.cfg.filter_word = wr_val[`CFD_FW_MSB:`CFD_FW_LSB]; // [RULE14]
            end
            n.cfg.sinc4_sel = wr_val[`CFD_SINC4_BIT];
            n.cfg.avg_select_lo = wr_val[`CFD_AVGLO_BIT];
            n.cfg.avg_select_hi = wr_val[`CFD_AVGHI_BIT];
            n.cfg.sixty_hz_notch_en = wr_val[`CFD_NOTCH_BIT];
            n.cfg.chop_en = wr_val[`CFD_CHOP_BIT];
         end else if (s.aw_addr == `CFD_CHAN_OFF) begin
            wr_val = merge({30'h0, s.chan}, s.wdata, s.wstrb);
            n.chan = wr_val[1:0];
         end
      end
      if (restart) begin // [RULE5]
         n.st = cfd_pkg::CFD_CONV;
         n.samp = '0;
         n.blk = '0;
         n.acc = '0;
         n.have_prev = 1'b0;
         n.pol = 1'b0;
         n.mod_rst = 1'b1;
         // chop needs a second settled period before the first result
         n.discard = n.cfg.chop_en; // [RULE4] [RULE11] [RULE13]
      end
      n.aw_rdy = !n.aw_got && !n.bvalid;
      n.w_rdy = !n.w_got && !n.bvalid;

      if (S_AXI_ARVALID && s.ar_rdy) begin
         n.ar_rdy = 1'b0;
         n.rvalid = 1'b1;
         n.rresp = `CFD_RESP_OKAY;
         case (S_AXI_ARADDR)
            `CFD_MODE_OFF: n.rdata = mode_rd;
            `CFD_CHAN_OFF: n.rdata = {30'h0, s.chan};
            `CFD_STAT_OFF: n.rdata = stat_rd;
            default: begin
               n.rdata = '0;
               n.rresp = `CFD_RESP_SLV;
            end
         endcase
      end else if (s.rvalid && S_AXI_RREADY) begin
         n.rvalid = 1'b0;
         n.ar_rdy = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s <= RST_S;
      end else if (CE) begin
         s <= n;
      end
   end

   assign MOD_RESET = s.mod_rst;
   assign CHOP_POL = s.pol;
   assign RES_VALID = s.res_valid;
   assign RES_DATA = s.fifo0;
   assign S_AXI_AWREADY = s.aw_rdy;
   assign S_AXI_WREADY = s.w_rdy;
   assign S_AXI_BVALID = s.bvalid;
   assign S_AXI_BRESP = s.bresp;
   assign S_AXI_ARREADY = s.ar_rdy;
   assign S_AXI_RVALID = s.rvalid;
   assign S_AXI_RDATA = s.rdata;
   assign S_AXI_RRESP = s.rresp;

   // helper: enabled cycles since the last clean conversion end
   logic [24:0] cyc_q;
   logic        clean_q;
   logic [24:0] per_m1;
   assign per_m1 = {15'(15'(mult) * 15'(s.cfg.filter_word)) - 15'h1, 10'h3ff};
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cyc_q <= '0;
         clean_q <= 1'b0;
      end else if (CE) begin
         if (restart || stall) begin
            cyc_q <= '0;
            clean_q <= 1'b0;
         end else if (conv_end) begin
            cyc_q <= '0;
            clean_q <= 1'b1;
         end else begin
            cyc_q <= cyc_q + 25'h1;
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   sequence seq_restarted;
      (CE && restart) ##1 1'b1;
   endsequence

   fw_range_a: assert property (s.cfg.filter_word != 10'h0) // [RULE3]
      else $error("filter word reached zero");
   chop_swap_a: assert property (CE && conv_end && !restart && s.cfg.chop_en // [RULE1]
      |=> CHOP_POL != $past(CHOP_POL))
      else $error("polarity not swapped at conversion end");
   chop_rate_a: assert property (CE && conv_end && clean_q && !fast && !s.cfg.sinc4_sel // [RULE2]
      |-> mult == 5'h03 && cyc_q == per_m1)
      else $error("chopped sinc3 period wrong");
   fast_rate_a: assert property (CE && conv_end && clean_q && fast // [RULE10]
      |-> mult == 5'(5'h03 + navg) && cyc_q == per_m1)
      else $error("fast settling period wrong");
   chop_settle_a: assert property (seq_restarted ##0 s.cfg.chop_en && !fast |-> s.discard) // [RULE4]
      else $error("chopped first period not discarded");
   mod_reset_a: assert property (CE && restart |=> MOD_RESET ##1 (!$past(CE) || !MOD_RESET)) // [RULE5]
      else $error("modulator reset pulse wrong");
   fast_settle_a: assert property (seq_restarted ##0 fast && !s.cfg.chop_en |-> !s.discard) // [RULE11]
      else $error("fast mode added latency");
   fast_chop_a: assert property (seq_restarted ##0 fast && s.cfg.chop_en |-> s.discard) // [RULE13]
      else $error("fast chop settles too soon");
   avg_off_a: assert property (!fast |-> navg == 5'h01 && shift == 3'h0) // [RULE9]
      else $error("postfilter active with averaging off");
   result_a: assert property (CE && push |=> RES_VALID && s.fcnt != 2'h0) // [RULE16]
      else $error("result not flagged");
   discard_a: assert property (CE && conv_end && s.discard && !pop |=> s.fcnt == $past(s.fcnt)) // [RULE4]
      else $error("unsettled result delivered");
endmodule
`default_nettype wire

// *** verification/cfd_front_model.sv ***
`default_nettype none
// modulator and result register seen from the decimator
module cfd_front_model (
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        CE,
   input  wire logic        MOD_RESET,
   input  wire logic        CHOP_POL,
   input  wire logic        RES_VALID,
   input  wire logic [31:0] RES_DATA,
   input  wire logic        level,
   input  wire logic        rdy_en,
   output logic             MOD_BIT,
   output logic             RES_READY,
   output int               word_cnt,
   output int               rst_cnt,
   output logic [31:0]      last_data,
   output logic             last_pol
);
   timeunit 1ns;
   timeprecision 1ps;
   // swapped inputs come back inverted, so the filter must undo the swap
   assign MOD_BIT   = level ^ CHOP_POL;
   assign RES_READY = rdy_en;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         word_cnt  <= 0;
         rst_cnt   <= 0;
         last_data <= 32'h0;
         last_pol  <= 1'b0;
      // words leave only on enabled edges, as the buffer pops
      end else if (CE) begin
         if (MOD_RESET) begin
            rst_cnt <= rst_cnt + 1;
         end
         if (RES_VALID && RES_READY) begin
            word_cnt  <= word_cnt + 1;
            last_data <= RES_DATA;
            last_pol  <= CHOP_POL;
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/chop_fast_settle_decimator_tb_top.sv ***
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s exp %0h got %0h", nm, e, g); end end
module chop_fast_settle_decimator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [31:0] mode;
      logic [15:0] per;
      logic [1:0]  k;
      logic        lvl;
   } cfd_row_s;
   logic        clk, mod_bit, res_ready, mod_reset, chop_pol, res_valid, awready, wready;
   logic        bvalid, arready, rvalid, p, last_pol;
   logic        rst_n = 1'b0, ce = 1'b1, level = 1'b1, rdy_en = 1'b1, awvalid = 1'b0;
   logic        wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] res_data, last_data, rdata, d, wdata = 32'h0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [1:0]  bresp, rresp, r;
   int          error_cnt, total_checks, word_cnt, rst_cnt, n, c;
   cfd_row_s    rows [9];

   cfd_decimator dut (
      .CLK(clk), .RESET_N(rst_n), .CE(ce), .MOD_BIT(mod_bit), .RES_READY(res_ready),
      .MOD_RESET(mod_reset), .CHOP_POL(chop_pol), .RES_VALID(res_valid), .RES_DATA(res_data),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   cfd_front_model mdl (
      .CLK(clk), .RESET_N(rst_n), .CE(ce), .MOD_RESET(mod_reset), .CHOP_POL(chop_pol),
      .RES_VALID(res_valid), .RES_DATA(res_data), .level(level), .rdy_en(rdy_en),
      .MOD_BIT(mod_bit), .RES_READY(res_ready), .word_cnt(word_cnt), .rst_cnt(rst_cnt),
      .last_data(last_data), .last_pol(last_pol));

   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic timeout;
      error_cnt++;
      summarize();
   endtask

   // leading edge keeps a ready release and the next raise in different steps
   task automatic axw(input logic [3:0] a, input logic [31:0] v);
      int t;
      logic pa, pw;
      @(posedge clk);
      t = 0;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         t++;
         if (pa && awready === 1'b1) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && wready === 1'b1) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1 && t < 50);
      r = bresp;
      bready <= 1'b0;
      if (t >= 50) timeout();
   endtask

   task automatic axr(input logic [3:0] a);
      int t;
      @(posedge clk);
      t = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         t++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && t < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (t >= 50) timeout();
   endtask

   task automatic wait_word;
      int c0;
      c0 = word_cnt;
      n = 0;
      while (word_cnt == c0 && n < 25000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 25000) timeout();
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      rows = '{'{32'h00000001, 16'd3072, 2'd1, 1'b1}, '{32'h00000002, 16'd6144, 2'd1, 1'b0},
               '{32'h00800001, 16'd3072, 2'd2, 1'b1}, '{32'h00900001, 16'd3072, 2'd2, 1'b0},
               '{32'h00008001, 16'd4096, 2'd1, 1'b1}, '{32'h00018001, 16'd5120, 2'd1, 1'b1},
               '{32'h00028001, 16'd11264, 2'd1, 1'b0}, '{32'h00038001, 16'd19456, 2'd1, 1'b1},
               '{32'h00818001, 16'd5120, 2'd2, 1'b1}};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK("pol", 1'b0, chop_pol);
      `CHK("valid", 1'b0, res_valid);
      axr(4'h0);
      `CHK("mode", 32'h60, d);
      axr(4'hc);
      `CHK("rresp", 2'h2, r);
      `CHK("rdata", 32'h0, d);
      axw(4'h8, 32'h1);
      `CHK("bresp", 2'h2, r);
      $display("test reset done");
      foreach (rows[i]) begin
         c = rst_cnt;
         level <= rows[i].lvl;
         axw(4'h0, rows[i].mode);
         `CHK("bresp", 2'h0, r);
         // a word finishing right at the write is old config, so skip it
         repeat (4) @(posedge clk);
         `CHK("restart", c + 1, rst_cnt);
         wait_word();
         `CHK("settle", 1'b1, n + 4 > rows[i].k * rows[i].per - 12 && n + 4 < rows[i].k * rows[i].per + 12);
         // one block of ones per word when the level is high
         `CHK("data", rows[i].lvl ? 32'h400 : 32'h0, last_data);
         if (rows[i].mode[23]) begin
            p = last_pol;
            wait_word();
            `CHK("period", 1'b1, n > rows[i].per - 3 && n < rows[i].per + 3);
            `CHK("swap", ~p, last_pol);
         end else begin
            `CHK("pol", 1'b0, chop_pol);
         end
         $display("row %0d done", i);
      end
      n = 0;
      while (chop_pol !== 1'b1 && n < 12000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 12000) timeout();
      c = rst_cnt;
      axw(4'h4, 32'h1);
      @(posedge clk);
      `CHK("chan pol", 1'b0, chop_pol);
      `CHK("chan rst", c + 1, rst_cnt);
      $display("test channel done");
      // word 96 keeps chopped sinc3 near 170 Hz at this clock
      axw(4'h0, 32'h00900060);
      axr(4'h8);
      `CHK("notch on", 1'b1, d[6]);
      `CHK("chop settle", 1'b1, d[5]);
      $display("test notch done");
      axw(4'h0, 32'h1);
      axw(4'h0, 32'h0);
      `CHK("fw0 resp", 2'h0, r);
      axr(4'h0);
      `CHK("fw0 kept", 32'h1, d);
      $display("test word zero done");
      rdy_en <= 1'b0;
      repeat (9500) @(posedge clk);
      `CHK("held valid", 1'b1, res_valid);
      axr(4'h8);
      `CHK("fill", 2'h2, d[4:3]);
      `CHK("hold", 1'b1, d[0]);
      rdy_en <= 1'b1;
      wait_word();
      `CHK("drain1", 1'b1, n < 4);
      wait_word();
      `CHK("drain2", 1'b1, n < 4);
      `CHK("drain data", 32'h400, last_data);
      $display("test stall done");
      ce <= 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b1;
      wait_word();
      // frozen edges push the next word back by exactly their count
      `CHK("ce freeze", 1'b1, n > 3069 && n < 3075);
      `CHK("ce data", 32'h400, last_data);
      $display("test enable done");
      summarize();
   end
endmodule
`default_nettype wire
